// ===== core/css_pkg.sv
package css_pkg;
   // Register port geometry
   localparam int CSS_AW = 4;
   localparam int CSS_DW = 8;
   // Register offsets
   localparam logic [3:0] OFS_SYS_CLK_CTRL = 4'h0;
   localparam logic [3:0] OFS_FAST_RC_CTRL = 4'h1;
   localparam logic [3:0] OFS_SLOW_XTAL_CTRL = 4'h2;
   // system_clock_control fields
   localparam int SCC_DIV_LSB = 5;
   localparam int SCC_FHS_BIT = 3;
   localparam int SCC_FSS_BIT = 2;
   localparam int SCC_FAST_IDLE_BIT = 1;
   localparam int SCC_SLOW_IDLE_BIT = 0;
   // fast_rc_control fields
   localparam int FRC_FREQ_LSB = 0;
   // slow_crystal_control fields
   localparam int SXC_EN_BIT = 0;
   localparam int SXC_SPEEDUP_BIT = 1;
   localparam int SXC_PINS_BIT = 2;
   localparam int SXC_READY_BIT = 3;
   localparam int SXC_LOCK_BIT = 4;
   // Reset values
   localparam logic [7:0] SCC_RST = 8'h00;
   localparam logic [7:0] FRC_RST = 8'h00;
   localparam logic [7:0] SXC_RST = 8'h00;
   // Divider code that picks the slow path
   localparam logic [2:0] DIV_SLOW = 3'h7;
   // Fast RC frequency codes
   localparam logic [1:0] FRQ_8MHZ = 2'h0;
   localparam logic [1:0] FRQ_12MHZ = 2'h1;
   localparam logic [1:0] FRQ_16MHZ = 2'h2;
   // Slow crystal start-up, in crystal cycles
   localparam logic [11:0] SXC_START_SPEEDUP = 12'h100;
   localparam logic [11:0] SXC_START_LOWPOWER = 12'h800;

   typedef struct packed {
      logic run;
      logic use_slow;
      logic [2:0] div_code;
   } css_cfg_s;

   localparam css_cfg_s CFG_RST = '{run: 1'b1, use_slow: 1'b0, div_code: 3'h0};

   typedef enum logic [2:0] {
      MODE_RUN = 3'b001,
      MODE_IDLE = 3'b010,
      MODE_SLEEP = 3'b100
   } css_mode_e;
endpackage : css_pkg

// ===== core/css_sync.sv
`timescale 1ns/10ps
module css_sync
   import css_pkg::*;
#(
   parameter int W = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Two stages; only the second stage is read by anyone
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : css_sync

// ===== core/css_clkgen.sv
`timescale 1ns/10ps
module css_clkgen
   import css_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fast_lvl,
   input wire logic slow_lvl,
   input css_cfg_s cfg,
   output logic clk_out,
   output logic switching
);
   css_cfg_s act_q;
   logic src;
   logic src_q;
   logic rise;
   logic take;
   logic follow;
   logic [5:0] cnt_q;
   logic clk_q;

   // Rising edges per half period, minus one
   function automatic logic [5:0] last_edge(input logic [2:0] code);
      last_edge = 6'((7'h01 << (code - 3'h1)) - 7'h01);
   endfunction : last_edge

   assign src = act_q.use_slow ? slow_lvl : fast_lvl;
   assign rise = src & ~src_q;
   assign take = !clk_q && (cfg != act_q);
   assign follow = act_q.use_slow || (act_q.div_code == 3'h0);
   assign switching = cfg != act_q;
   assign clk_out = clk_q;

   // New source or ratio only while the output is low; edge history is
   // forced high so a source caught mid-high phase cannot start a runt
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         act_q <= CFG_RST;
         src_q <= 1'b1;
      end else if (take) begin
         act_q <= cfg;
         src_q <= 1'b1;
      end else begin
         src_q <= src;
      end
   end

   // Output phase: follow the source, or toggle every few source edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_q <= 1'b0;
         cnt_q <= 6'h00;
      end else if (take) begin
         cnt_q <= 6'h00;
      end else if (!act_q.run) begin
         clk_q <= 1'b0;
      end else if (follow) begin
         if (rise) begin
            clk_q <= 1'b1;
         end else if (!src) begin
            clk_q <= 1'b0;
         end
      end else if (rise) begin
         if (cnt_q == last_edge(act_q.div_code)) begin
            clk_q <= ~clk_q;
            cnt_q <= 6'h00;
         end else begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_gate_holds_low: assert property (!act_q.run |=> !clk_out)
      else $error("System clock not held low while gated");
   chk_switch_when_low: assert property (!$stable(act_q) |-> !$past(clk_out))
      else $error("Clock configuration changed while output high");
   chk_rise_on_edge: assert property ($rose(clk_out) |-> $past(rise))
      else $error("System clock rose without a source edge");
endmodule : css_clkgen

// ===== core/css_clock_select.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - Divider select field picks fast or slow path and the divided frequency.
// - Low speed source select bit picks slow RC or slow crystal for sub clock.
// - High speed source select bit picks fast crystal or fast RC for high clock.
// - Exactly one fast and one slow oscillator are always selected.
// - After power-on the fast crystal is the clock source.
// - Fast RC runs at 8, 12 or 16 MHz.
// - Slow crystal starts on enable write of 1; usable after start-up delay.
// - Slow crystal mode bit: 0 low-power, 1 speed-up.
// - Mode changes ignored once slow crystal drives the system clock.
// - Slow crystal is valid in both modes; low-power starts slower.
// - Pin-share bit gives slow crystal pins to oscillator or general I/O.
// - Sleep or idle gates the system clock; an independent clock may run.
// - Slow oscillators also clock the watchdog and time base.
// - Fast path divides the high clock by 1 to 64 per divider field.
module css_clock_select
   import css_pkg::*;
#(
   parameter logic [11:0] START_SPEEDUP = SXC_START_SPEEDUP,
   parameter logic [11:0] START_LOWPOWER = SXC_START_LOWPOWER
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [CSS_AW-1:0] reg_addr,
   input wire logic [CSS_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CSS_DW-1:0] reg_rdata,
   input wire logic fast_crystal_osc,
   input wire logic fast_internal_rc,
   input wire logic slow_internal_rc,
   input wire logic slow_crystal_osc,
   input wire logic halt_req,
   input wire logic wake_req,
   output logic sys_clk,
   output logic clk_switching,
   output logic fast_crystal_run,
   output logic fast_rc_run,
   output logic [1:0] fast_rc_freq_sel,
   output logic slow_crystal_run,
   output logic slow_crystal_speedup,
   output logic slow_crystal_ready,
   output logic slow_crystal_pins_osc,
   output logic wdt_clk,
   output logic timebase_clk,
   output logic cpu_halted
);
   logic [2:0] div_q;
   logic fhs_q;
   logic fss_q;
   logic fast_idle_q;
   logic slow_idle_q;
   logic [1:0] frq_q;
   logic sxc_en_q;
   logic sxc_sp_q;
   logic sxc_pins_q;
   logic [11:0] sxc_cnt_q;
   logic sxc_ready_q;
   logic lxt_prev_q;
   logic wdt_q;
   logic tb_q;
   logic [CSS_DW-1:0] rdata_q;
   logic [CSS_DW-1:0] rd_mux;
   css_mode_e mode_q;
   css_mode_e mode_d;
   logic [3:0] osc_s;
   logic hxt_s;
   logic fast_internal_rc_s;
   logic slow_internal_rc_s;
   logic lxt_s;
   logic fast_lvl;
   logic sub_lvl;
   logic fast_run;
   logic sub_run;
   logic lock;
   logic [11:0] sxc_target;
   css_cfg_s cfg;
   logic fhs_use_q;
   logic fss_use_q;
   logic fast_ok_q;
   logic sub_ok_q;

   // Write strobe aimed at one register
   function automatic logic wr_hit(input logic wr, input logic [3:0] a,
                                   input logic [3:0] ofs);
      wr_hit = wr && (a == ofs);
   endfunction : wr_hit

   // Oscillator levels come from other clocks; sample through two stages
   css_sync #(.W(4)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({fast_crystal_osc, fast_internal_rc, slow_internal_rc, slow_crystal_osc}),
      .sync_out(osc_s)
   );
   assign {hxt_s, fast_internal_rc_s, slow_internal_rc_s, lxt_s} = osc_s;

   // One of each pair is always chosen; a single bit cannot select none.
   // A newly chosen source stays masked low until it is itself seen low,
   // so the clock generator never sees a false edge at the handover
   assign fast_lvl = fast_ok_q & (fhs_use_q ? fast_internal_rc_s : hxt_s);
   assign sub_lvl = sub_ok_q & (fss_use_q ? lxt_s : slow_internal_rc_s);

   // Source bits reach the clock path only while clock and old source are low;
   // costs a few cycles per switch, and a disabled oscillator must rest low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fhs_use_q <= SCC_RST[SCC_FHS_BIT];
         fss_use_q <= SCC_RST[SCC_FSS_BIT];
         fast_ok_q <= 1'b1;
         sub_ok_q <= 1'b1;
      end else begin
         if (fhs_use_q != fhs_q && !sys_clk && !fast_lvl) begin
            fhs_use_q <= fhs_q;
            fast_ok_q <= 1'b0;
         end else if (!(fhs_use_q ? fast_internal_rc_s : hxt_s)) begin
            fast_ok_q <= 1'b1;
         end
         if (fss_use_q != fss_q && !sys_clk && !sub_lvl) begin
            fss_use_q <= fss_q;
            sub_ok_q <= 1'b0;
         end else if (!(fss_use_q ? lxt_s : slow_internal_rc_s)) begin
            sub_ok_q <= 1'b1;
         end
      end
   end

   // Crystal mode frozen while the slow crystal feeds the system clock
   assign lock = (div_q == DIV_SLOW) && fss_q;

   // system_clock_control: power-on picks the fast crystal, undivided
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_q <= SCC_RST[SCC_DIV_LSB+:3];
         fhs_q <= SCC_RST[SCC_FHS_BIT];
         fss_q <= SCC_RST[SCC_FSS_BIT];
         fast_idle_q <= SCC_RST[SCC_FAST_IDLE_BIT];
         slow_idle_q <= SCC_RST[SCC_SLOW_IDLE_BIT];
      end else if (wr_hit(reg_wr, reg_addr, OFS_SYS_CLK_CTRL)) begin
         div_q <= reg_wdata[SCC_DIV_LSB+:3];
         fhs_q <= reg_wdata[SCC_FHS_BIT];
         fss_q <= reg_wdata[SCC_FSS_BIT];
         fast_idle_q <= reg_wdata[SCC_FAST_IDLE_BIT];
         slow_idle_q <= reg_wdata[SCC_SLOW_IDLE_BIT];
      end
   end

   // fast_rc_control: the spare code is refused, last frequency kept
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         frq_q <= FRC_RST[FRC_FREQ_LSB+:2];
      end else if (wr_hit(reg_wr, reg_addr, OFS_FAST_RC_CTRL) &&
                   reg_wdata[FRC_FREQ_LSB+:2] != 2'h3) begin
         frq_q <= reg_wdata[FRC_FREQ_LSB+:2];
      end
   end

   // slow_crystal_control: enable, mode and pin sharing
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sxc_en_q <= SXC_RST[SXC_EN_BIT];
         sxc_sp_q <= SXC_RST[SXC_SPEEDUP_BIT];
         sxc_pins_q <= SXC_RST[SXC_PINS_BIT];
      end else if (wr_hit(reg_wr, reg_addr, OFS_SLOW_XTAL_CTRL)) begin
         sxc_en_q <= reg_wdata[SXC_EN_BIT];
         sxc_pins_q <= reg_wdata[SXC_PINS_BIT];
         if (!lock) begin
            sxc_sp_q <= reg_wdata[SXC_SPEEDUP_BIT];
         end
      end
   end

   // Start-up delay counted in crystal cycles; low-power waits longer
   assign sxc_target = sxc_sp_q ? START_SPEEDUP : START_LOWPOWER;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sxc_cnt_q <= 12'h000;
         sxc_ready_q <= 1'b0;
         lxt_prev_q <= 1'b0;
      end else begin
         lxt_prev_q <= lxt_s;
         if (!sxc_en_q) begin
            sxc_cnt_q <= 12'h000;
            sxc_ready_q <= 1'b0;
         end else if (lxt_s && !lxt_prev_q && !sxc_ready_q) begin
            if (sxc_cnt_q >= sxc_target - 12'h001) begin
               sxc_ready_q <= 1'b1;
            end
            sxc_cnt_q <= sxc_cnt_q + 12'h001;
         end
      end
   end

   // Halt enters idle if either idle enable is set, otherwise sleep
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_RUN: begin
            if (halt_req) begin
               mode_d = (fast_idle_q || slow_idle_q) ? MODE_IDLE : MODE_SLEEP;
            end
         end
         MODE_IDLE: begin
            if (wake_req) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_SLEEP: begin
            if (wake_req) begin
               mode_d = MODE_RUN;
            end
         end
         default: mode_d = MODE_RUN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_q <= MODE_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Oscillator enables follow the mode and the idle enables
   assign fast_run = (mode_q == MODE_RUN) || ((mode_q == MODE_IDLE) && fast_idle_q);
   assign sub_run = (mode_q == MODE_RUN) || ((mode_q == MODE_IDLE) && slow_idle_q);

   // System clock generator; it waits for a low phase before switching
   assign cfg = '{run: (mode_q == MODE_RUN),
                  use_slow: (div_q == DIV_SLOW),
                  div_code: div_q};

   css_clkgen u_clkgen (
      .ref_clk(ref_clk),
      .rst(rst),
      .fast_lvl(fast_lvl),
      .slow_lvl(sub_lvl),
      .cfg(cfg),
      .clk_out(sys_clk),
      .switching(clk_switching)
   );

   // Watchdog keeps the slow RC even in sleep; time base uses the sub clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdt_q <= 1'b0;
         tb_q <= 1'b0;
      end else begin
         wdt_q <= slow_internal_rc_s;
         tb_q <= sub_run & sub_lvl;
      end
   end

   // Register read view
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         OFS_SYS_CLK_CTRL: begin
            rd_mux[SCC_DIV_LSB+:3] = div_q;
            rd_mux[SCC_FHS_BIT] = fhs_q;
            rd_mux[SCC_FSS_BIT] = fss_q;
            rd_mux[SCC_FAST_IDLE_BIT] = fast_idle_q;
            rd_mux[SCC_SLOW_IDLE_BIT] = slow_idle_q;
         end
         OFS_FAST_RC_CTRL: rd_mux[FRC_FREQ_LSB+:2] = frq_q;
         OFS_SLOW_XTAL_CTRL: begin
            rd_mux[SXC_EN_BIT] = sxc_en_q;
            rd_mux[SXC_SPEEDUP_BIT] = sxc_sp_q;
            rd_mux[SXC_PINS_BIT] = sxc_pins_q;
            rd_mux[SXC_READY_BIT] = sxc_ready_q;
            rd_mux[SXC_LOCK_BIT] = lock;
         end
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data valid only in the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Output drive
   assign reg_rdata = rdata_q;
   assign fast_crystal_run = fast_run && !fhs_q;
   assign fast_rc_run = fast_run && fhs_q;
   assign fast_rc_freq_sel = frq_q;
   assign slow_crystal_run = sxc_en_q;
   assign slow_crystal_speedup = sxc_sp_q;
   assign slow_crystal_ready = sxc_ready_q;
   assign slow_crystal_pins_osc = sxc_pins_q;
   assign wdt_clk = wdt_q;
   assign timebase_clk = tb_q;
   assign cpu_halted = mode_q != MODE_RUN;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_reset_fast_xtal: assert property ($fell(rst) |-> fast_crystal_run && !fast_rc_run
                                         && div_q == 3'h0)
      else $error("Power-on source is not the undivided fast crystal");
   chk_one_fast_src: assert property (fast_run |-> fast_crystal_run != fast_rc_run)
      else $error("Not exactly one fast oscillator running");
   chk_mode_lock: assert property (lock && reg_wr && reg_addr == OFS_SLOW_XTAL_CTRL
                                   |=> $stable(sxc_sp_q))
      else $error("Crystal mode changed while it drives the system clock");
   chk_mode_write: assert property (!lock && reg_wr && reg_addr == OFS_SLOW_XTAL_CTRL
                                    |=> sxc_sp_q == $past(reg_wdata[SXC_SPEEDUP_BIT]))
      else $error("Crystal mode write not taken");
   chk_ready_needs_en: assert property (!sxc_en_q |=> !slow_crystal_ready)
      else $error("Slow crystal ready without enable");
   chk_rc_freq_legal: assert property (fast_rc_freq_sel != 2'h3)
      else $error("Fast RC frequency code illegal");
   chk_halt_gates: assert property (mode_q == MODE_RUN && halt_req
                                    |=> cpu_halted && !u_clkgen.cfg.run)
      else $error("Halt did not gate the system clock");
   chk_wdt_follows: assert property (##1 wdt_clk == $past(slow_internal_rc_s))
      else $error("Watchdog clock does not follow the slow RC");
   chk_path_select: assert property (!clk_switching |->
                                     u_clkgen.act_q.use_slow == (div_q == DIV_SLOW))
      else $error("Path select disagrees with divider field");
   chk_read_once: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("Read data outside the answer cycle");

   cov_idle: cover property (mode_q == MODE_RUN ##1 mode_q == MODE_IDLE);
   cov_sleep: cover property (mode_q == MODE_RUN ##1 mode_q == MODE_SLEEP);
   cov_xtal_ready: cover property ($rose(slow_crystal_ready));
   cov_slow_path: cover property (u_clkgen.act_q.use_slow && $rose(sys_clk));
endmodule : css_clock_select

// ===== tb/css_clock_select_tb.sv
`timescale 1ns/10ps
module css_clock_select_tb;
   import css_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [CSS_AW-1:0] reg_addr = 4'h0;
   logic [CSS_DW-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [CSS_DW-1:0] reg_rdata;
   logic fast_crystal_osc = 1'b0;
   logic fast_internal_rc = 1'b0;
   logic slow_internal_rc = 1'b0;
   logic slow_crystal_osc = 1'b0;
   logic halt_req = 1'b0;
   logic wake_req = 1'b0;
   logic sys_clk, clk_switching, fast_crystal_run, fast_rc_run;
   logic [1:0] fast_rc_freq_sel;
   logic slow_crystal_run, slow_crystal_speedup, slow_crystal_ready;
   logic slow_crystal_pins_osc, wdt_clk, timebase_clk, cpu_halted;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   int sys_rises = 0;
   int wdt_rises = 0;
   logic sys_d = 1'b0;
   logic wdt_d = 1'b0;
   int tb_rises = 0;
   logic tb_d = 1'b0;

   // Short start-up targets keep the run brief
   css_clock_select #(.START_SPEEDUP(12'h004), .START_LOWPOWER(12'h010)) u_css_clock_select (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fast_crystal_osc(fast_crystal_osc), .fast_internal_rc(fast_internal_rc),
      .slow_internal_rc(slow_internal_rc), .slow_crystal_osc(slow_crystal_osc),
      .halt_req(halt_req), .wake_req(wake_req), .sys_clk(sys_clk),
      .clk_switching(clk_switching), .fast_crystal_run(fast_crystal_run),
      .fast_rc_run(fast_rc_run), .fast_rc_freq_sel(fast_rc_freq_sel),
      .slow_crystal_run(slow_crystal_run), .slow_crystal_speedup(slow_crystal_speedup),
      .slow_crystal_ready(slow_crystal_ready), .slow_crystal_pins_osc(slow_crystal_pins_osc),
      .wdt_clk(wdt_clk), .timebase_clk(timebase_clk), .cpu_halted(cpu_halted));

   // Clock at 200 MHz
   always #2.5 ref_clk = ~ref_clk;

   // Oscillators: periods of 8, 6, 32 and 12 reference cycles, all far below ref rate
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) fast_crystal_osc <= ~fast_crystal_osc;
      if (cyc % 3 == 2) fast_internal_rc <= ~fast_internal_rc;
      if (cyc % 16 == 15) slow_internal_rc <= ~slow_internal_rc;
      if (cyc % 6 == 5) slow_crystal_osc <= ~slow_crystal_osc;
   end

   // Rising-edge counters on the generated clocks
   always @(posedge ref_clk) begin
      sys_d <= sys_clk;
      wdt_d <= wdt_clk;
      if (sys_clk === 1'b1 && sys_d === 1'b0) sys_rises <= sys_rises + 1;
      if (wdt_clk === 1'b1 && wdt_d === 1'b0) wdt_rises <= wdt_rises + 1;
      tb_d <= timebase_clk;
      if (timebase_clk === 1'b1 && tb_d === 1'b0) tb_rises <= tb_rises + 1;
   end

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   // Edge counts are sampled against free-running sources, so allow a slack
   task automatic chk_cnt(input string what, input int exp, input int got, input int tol);
      n_compared++;
      if (got < exp - tol || got > exp + tol) begin
         mismatches++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_cnt

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk8(what, exp, reg_rdata);
   endtask : rd_chk

   // Let a pending switch land before measuring, bounded
   task automatic settle;
      int k;
      k = 0;
      repeat (40) @(posedge ref_clk);
      while (clk_switching !== 1'b0 && k < 2000) begin
         @(posedge ref_clk);
         k++;
      end
      chk8("clk_switching", 8'h00, {7'h0, clk_switching});
   endtask : settle

   task automatic rises(input string what, input int n, input int exp, input int tol);
      int s0;
      settle();
      s0 = sys_rises;
      repeat (n) @(posedge ref_clk);
      chk_cnt(what, exp, sys_rises - s0, tol);
   endtask : rises

   task automatic t_reset;
      rd_chk("scc", OFS_SYS_CLK_CTRL, SCC_RST);
      rd_chk("frc", OFS_FAST_RC_CTRL, FRC_RST);
      rd_chk("sxc", OFS_SLOW_XTAL_CTRL, SXC_RST);
      rd_chk("unmapped", 4'hf, 8'h00);
      chk8("xtal_run", 8'h01, {7'h0, fast_crystal_run});
      chk8("rc_run", 8'h00, {7'h0, fast_rc_run});
      rises("xtal div1", 200, 25, 1);
   endtask : t_reset

   task automatic t_fast_rc;
      logic [1:0] exp;
      exp = FRQ_8MHZ;
      for (int c = 3; c >= 0; c--) begin
         wr(OFS_FAST_RC_CTRL, 8'(c));
         if (c != 3) exp = 2'(c);
         rd_chk("frc code", OFS_FAST_RC_CTRL, {6'h0, exp});
         chk8("rc freq", {6'h0, exp}, {6'h0, fast_rc_freq_sel});
      end
      wr(OFS_SYS_CLK_CTRL, 8'h08);
      chk8("rc_run", 8'h01, {7'h0, fast_rc_run});
      chk8("xtal_run", 8'h00, {7'h0, fast_crystal_run});
      rises("rc div1", 120, 20, 1);
      wr(OFS_SYS_CLK_CTRL, 8'h00);
   endtask : t_fast_rc

   // Ratios 1..64: window of eight output periods each
   task automatic t_div;
      for (int k = 0; k < 7; k++) begin
         wr(OFS_SYS_CLK_CTRL, {3'(k), 5'h00});
         rd_chk("scc div", OFS_SYS_CLK_CTRL, {3'(k), 5'h00});
         rises("fast div", 64 << k, 8, 1);
      end
   endtask : t_div

   task automatic t_slow;
      int k;
      wr(OFS_SLOW_XTAL_CTRL, 8'h07);
      chk8("sx run", 8'h01, {7'h0, slow_crystal_run});
      chk8("sx speedup", 8'h01, {7'h0, slow_crystal_speedup});
      chk8("sx pins", 8'h01, {7'h0, slow_crystal_pins_osc});
      chk8("sx early", 8'h00, {7'h0, slow_crystal_ready});
      k = 0;
      while (slow_crystal_ready !== 1'b1 && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      chk8("sx ready fast", 8'h01, {7'h0, slow_crystal_ready});
      wr(OFS_SLOW_XTAL_CTRL, 8'h04);
      @(posedge ref_clk);
      #1;
      chk8("sx off", 8'h00, {7'h0, slow_crystal_ready});
      chk8("sx pins io", 8'h01, {7'h0, slow_crystal_pins_osc});
      wr(OFS_SLOW_XTAL_CTRL, 8'h01);
      chk8("sx pins gpio", 8'h00, {7'h0, slow_crystal_pins_osc});
      wr(OFS_SLOW_XTAL_CTRL, 8'h05);
      repeat (100) @(posedge ref_clk);
      chk8("sx lowpower slow", 8'h00, {7'h0, slow_crystal_ready});
      repeat (400) @(posedge ref_clk);
      chk8("sx lowpower ready", 8'h01, {7'h0, slow_crystal_ready});
      wr(OFS_SLOW_XTAL_CTRL, 8'h07);
      chk8("sx mode on", 8'h01, {7'h0, slow_crystal_speedup});
      wr(OFS_SLOW_XTAL_CTRL, 8'h05);
      chk8("sx mode off", 8'h00, {7'h0, slow_crystal_speedup});
      wr(OFS_SYS_CLK_CTRL, 8'he4);
      rises("slow xtal", 240, 20, 1);
      wr(OFS_SLOW_XTAL_CTRL, 8'h07);
      chk8("sx locked", 8'h00, {7'h0, slow_crystal_speedup});
      rd_chk("sx lock read", OFS_SLOW_XTAL_CTRL, 8'h1d);
      wr(OFS_SYS_CLK_CTRL, 8'he0);
      rises("slow rc", 320, 10, 1);
      wr(OFS_SYS_CLK_CTRL, 8'h00);
   endtask : t_slow

   // Sleep, then idle with both idle enables: system clock gated in both,
   // watchdog clock always running, time base only in idle
   task automatic t_halt;
      int w0;
      int t0;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_SYS_CLK_CTRL, 8'(3 * i));
         settle();
         @(posedge ref_clk);
         halt_req <= 1'b1;
         @(posedge ref_clk);
         halt_req <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk8("halted", 8'h01, {7'h0, cpu_halted});
         chk8("fast idle run", 8'(i), {7'h0, fast_crystal_run});
         rises("gated", 320, 0, 0);
         w0 = wdt_rises;
         t0 = tb_rises;
         repeat (320) @(posedge ref_clk);
         chk_cnt("wdt rises", 10, wdt_rises - w0, 1);
         chk_cnt("tb rises", 10 * i, tb_rises - t0, i);
         wake_req <= 1'b1;
         @(posedge ref_clk);
         wake_req <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk8("woken", 8'h00, {7'h0, cpu_halted});
         rises("after wake", 200, 25, 1);
      end
   endtask : t_halt

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // Watchdog: the sequence needs roughly 12000 cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      mismatches++;
      $display("BAD watchdog expected done seen hang");
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_fast_rc();
      t_div();
      t_slow();
      t_halt();
      wrap_up();
   end
endmodule : css_clock_select_tb
